// ===== rtl/lram_params.svh
// Constants of the large dual-port RAM block: geometry, width codes,
// register offsets and reset values. Included by every design file except the package.
`ifndef LRAM_PARAMS_SVH
`define LRAM_PARAMS_SVH
`define LRAM_ROWS 4096
`define LRAM_LANES 16
`define LRAM_LANE_W 9
`define LRAM_ADDR_W 16
`define LRAM_PORT_DW 72
`define LRAM_PORT_BE 8
`define LRAM_W9 3'h0
`define LRAM_W72 3'h3
`define LRAM_W144 3'h4
`define LRAM_FULL_DEPTH 17'h10000
`define LRAM_OFF_CFG 4'h0
`define LRAM_OFF_STAT 4'h4
`define LRAM_CFG_RST 11'h400
`endif

// ===== rtl/lram_pkg.sv
// Types of the large dual-port RAM block.
// Assumes lram_params.svh is included by the files that use it.
package lram_pkg;
   typedef enum logic [1:0] {LRAM_TDP, LRAM_SDP, LRAM_SP, LRAM_FIFO} lram_mode_type;
   // One port's request as the fabric drives it
   typedef struct packed {
      logic we;          // Write select
      logic rs;          // read_strobe, simple dual-port and FIFO read side
      logic [7:0] be;    // Lane enables
      logic [15:0] addr; // Word address at the port's width
      logic [71:0] din;  // Write data
   } lram_req_type;
   // Configuration word, low bits of the config register
   typedef struct packed {
      logic nine;      // 1: 9-bit lanes, 0: 8-bit lanes
      logic byp_b;     // Port B output register bypassed
      logic byp_a;     // Port A output register bypassed
      logic [2:0] wb;  // Port B width code
      logic [2:0] wa;  // Port A width code
      logic [1:0] mode;
   } lram_cfg_type;
   typedef struct packed {
      logic [16:0] count;
      logic full;
      logic empty;
      logic refused;
   } lram_stat_type;
endpackage : lram_pkg

// ===== rtl/lram_out.sv
// Read output stage of one port: optional output register.
// Assumes d is the array read path of the same clock.
`timescale 1ns/10ps
`include "lram_params.svh"
module lram_out #(
   parameter int W = `LRAM_PORT_DW
) (
   input wire logic clk,           // Port clock
   input wire logic rst_n,         // Async clear, active low
   input wire logic load,          // A read happened this cycle
   input wire logic adv,           // Port clock enable
   input wire logic bypass,        // Output register bypassed
   input wire logic [W-1:0] d,     // Array read path
   output logic [W-1:0] q          // Read data
);
   logic [W-1:0] mid_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mid_q <= '0;
      end else if (load) begin
         mid_q <= d;
      end
   end

   // Bypass takes the array path straight away, else one stage later
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else if (bypass) begin
         if (load) begin
            q <= d;
         end
      end else if (adv) begin
         q <= mid_q;
      end
   end
endmodule : lram_out

// ===== rtl/lram_top.sv
// Large dual-port RAM block with Avalon-MM configuration slave.
// Assumes both ports are driven by fabric logic on clk.
//
// The register offsets and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/10ps
`include "lram_params.svh"
module lram_top (
   input wire logic clk,                    // 50 MHz clock
   input wire logic resetn,                 // Async reset, active low
   input wire logic [3:0] avs_address,      // Byte address
   input wire logic avs_read,               // Read request
   input wire logic avs_write,              // Write request
   input wire logic [31:0] avs_writedata,   // Write data
   output logic [31:0] avs_readdata,        // Read data
   output logic avs_waitrequest,            // Wait, active high
   input wire logic clr_a,                  // Port A clear, active high
   input wire logic ce_a,                   // Port A clock enable
   input wire lram_pkg::lram_req_type req_a, // Port A request
   output logic [71:0] dout_a,              // Port A read data
   input wire logic clr_b,                  // Port B clear, active high
   input wire logic ce_b,                   // Port B clock enable
   input wire lram_pkg::lram_req_type req_b, // Port B request
   output logic [71:0] dout_b,              // Port B read data
   output logic fifo_full,                  // FIFO full
   output logic fifo_empty                  // FIFO empty
);
   // Array, parity bits included, no reset or preload
   logic [8:0] mem [0:`LRAM_ROWS-1][0:`LRAM_LANES-1];

   logic rst_a_n;
   logic rst_b_n;
   lram_pkg::lram_req_type ra_q;
   lram_pkg::lram_req_type rb_q;
   logic act_a_q;
   logic act_b_q;
   lram_pkg::lram_cfg_type cfg_q;
   lram_pkg::lram_mode_type mode;
   logic wait_q;
   logic [31:0] rdata_q;
   logic err_q;
   logic bus_go;
   logic wr_acc;
   logic cfg_load;
   logic [15:0] wptr_q;
   logic [15:0] rptr_q;
   logic [16:0] cnt_q;
   logic [16:0] cnt_d;
   logic [16:0] depth;
   logic push;
   logic pop;
   logic wide;
   logic [15:0] waddr_a;
   logic [15:0] raddr_a;
   logic [15:0] raddr_b;
   logic [15:0] unit_a;
   logic [15:0] unit_b;
   logic [143:0] wsrc_a;
   logic [15:0] wbe_a;
   logic [15:0] mask_a;
   logic [15:0] mask_b;
   logic [8:0] lane_a [0:`LRAM_LANES-1];
   logic [8:0] lane_b [0:`LRAM_LANES-1];
   logic wen_a;
   logic wen_b;
   logic rd_a;
   logic rd_b;
   logic [71:0] arr_a;
   logic [71:0] arr_b;

   assign mode = lram_pkg::lram_mode_type'(cfg_q.mode);
   assign wide = (cfg_q.wa == `LRAM_W144);

   // Lane base and row of a word address at width code w
   function automatic logic [15:0] unit_of(input logic [15:0] addr, input logic [2:0] w);
      return 16'(addr << w);
   endfunction : unit_of

   function automatic logic cfg_ok(input lram_pkg::lram_cfg_type c);
      logic ok;
      ok = (c.wa <= `LRAM_W144) && (c.wb <= `LRAM_W144);
      unique case (lram_pkg::lram_mode_type'(c.mode))
         lram_pkg::LRAM_TDP: ok = ok && c.wa <= `LRAM_W72 && c.wb <= `LRAM_W72;
         lram_pkg::LRAM_SDP: ok = ok && ((c.wa == `LRAM_W144) == (c.wb == `LRAM_W144));
         lram_pkg::LRAM_SP: ok = ok && c.wa <= `LRAM_W72;
         lram_pkg::LRAM_FIFO: ok = ok && c.wa == c.wb && c.wa <= `LRAM_W72;
      endcase
      return ok;
   endfunction : cfg_ok

   // Lanes written by one port; lanes outside the mask keep their value
   function automatic logic [15:0] wr_mask(input logic [15:0] addr, input logic [2:0] w,
                                           input logic [15:0] be);
      logic [15:0] m;
      logic [3:0] base;
      logic [3:0] k;
      logic [4:0] nl;
      m = '0;
      base = 4'(unit_of(addr, w));
      nl = 5'(5'h01 << w);
      for (int i = 0; i < `LRAM_LANES; i++) begin
         k = 4'(i) - base;
         // Lane enables act from x18 upward, x9 writes on select alone
         m[i] = ({1'b0, k} < nl) && (w == `LRAM_W9 || be[k]);
      end
      return m;
   endfunction : wr_mask

   // Read word packed into a port's 72 data bits
   function automatic logic [71:0] rd_pack(input logic [15:0] addr, input logic [2:0] w,
                                           input logic nine, input logic [3:0] half);
      logic [71:0] d;
      logic [15:0] u;
      logic [4:0] nl;
      logic [8:0] ln;
      d = '0;
      u = unit_of(addr, w);
      nl = 5'(5'h01 << w);
      for (int i = 0; i < `LRAM_PORT_BE; i++) begin
         ln = mem[u[15:4]][u[3:0] + 4'(i) + half];
         if (5'(i) < nl) begin
            if (nine) begin
               d[9*i +: 9] = ln;
            end else begin
               d[8*i +: 8] = ln[7:0];
            end
         end
      end
      return d;
   endfunction : rd_pack

   // Port clears reach registers only
   assign rst_a_n = resetn & ~clr_a;
   assign rst_b_n = resetn & ~clr_b;

   // Each port request is registered on its port clock enable
   always_ff @(posedge clk or negedge rst_a_n) begin
      if (!rst_a_n) begin
         ra_q <= '0;
         act_a_q <= 1'b0;
      end else begin
         act_a_q <= ce_a;
         if (ce_a) begin
            ra_q <= req_a;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b_n) begin
      if (!rst_b_n) begin
         rb_q <= '0;
         act_b_q <= 1'b0;
      end else begin
         act_b_q <= ce_b;
         if (ce_b) begin
            rb_q <= req_b;
         end
      end
   end

   // Avalon slave: one wait cycle, then the request is taken
   assign bus_go = (avs_read | avs_write) & wait_q;
   assign wr_acc = avs_write & ~wait_q;
   assign cfg_load = wr_acc && avs_address == `LRAM_OFF_CFG &&
                     cfg_ok(avs_writedata[$bits(lram_pkg::lram_cfg_type)-1:0]);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= ~bus_go;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= '0;
      end else if (bus_go && avs_read) begin
         unique case (avs_address)
            `LRAM_OFF_CFG: rdata_q <= 32'(cfg_q);
            `LRAM_OFF_STAT: rdata_q <= 32'({cnt_q, fifo_full, fifo_empty, err_q});
            default: rdata_q <= '0;
         endcase
      end
   end

   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;

   // Mode and widths; a forbidden pairing is refused and flagged
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cfg_q <= `LRAM_CFG_RST;
      end else if (cfg_load) begin
         cfg_q <= avs_writedata[$bits(lram_pkg::lram_cfg_type)-1:0];
      end
   end

   // Refused flag: write one to clear, a new refusal wins
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         err_q <= 1'b0;
      end else if (wr_acc && avs_address == `LRAM_OFF_CFG && !cfg_load) begin
         err_q <= 1'b1;
      end else if (wr_acc && avs_address == `LRAM_OFF_STAT && avs_writedata[0]) begin
         err_q <= 1'b0;
      end
   end

   // FIFO pointers in words of the configured width
   assign depth = `LRAM_FULL_DEPTH >> cfg_q.wa;
   assign push = mode == lram_pkg::LRAM_FIFO && act_a_q && ra_q.we && cnt_q != depth;
   assign pop = mode == lram_pkg::LRAM_FIFO && act_b_q && rb_q.rs && cnt_q != '0;

   always_comb begin
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + 17'h00001;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 17'h00001;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q <= '0;
         fifo_full <= 1'b0;
         fifo_empty <= 1'b1;
      end else if (cfg_load) begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q <= '0;
         fifo_full <= 1'b0;
         fifo_empty <= 1'b1;
      end else begin
         if (push) begin
            wptr_q <= (wptr_q + 16'h0001) & 16'(depth - 17'h00001);
         end
         if (pop) begin
            rptr_q <= (rptr_q + 16'h0001) & 16'(depth - 17'h00001);
         end
         cnt_q <= cnt_d;
         fifo_full <= cnt_d == depth;
         fifo_empty <= cnt_d == '0;
      end
   end

   // Write side: 144-bit width joins both data and lane sets
   always_comb begin
      waddr_a = (mode == lram_pkg::LRAM_FIFO) ? wptr_q : ra_q.addr;
      if (wide) begin
         wsrc_a = {rb_q.din, ra_q.din};
         wbe_a = {rb_q.be, ra_q.be};
      end else begin
         wsrc_a = {72'h0, ra_q.din};
         wbe_a = {8'h00, ra_q.be};
      end
   end

   // Write select decides write or read in true dual and single port; simple dual and FIFO reads use read_strobe
   assign wen_a = act_a_q && ra_q.we && (mode != lram_pkg::LRAM_FIFO || push);
   assign wen_b = act_b_q && rb_q.we && mode == lram_pkg::LRAM_TDP;
   assign mask_a = wr_mask(waddr_a, cfg_q.wa, wbe_a);
   assign mask_b = wr_mask(rb_q.addr, cfg_q.wb, {8'h00, rb_q.be});
   assign unit_a = unit_of(waddr_a, cfg_q.wa);
   assign unit_b = unit_of(rb_q.addr, cfg_q.wb);

   // Lane i of the data feeds the lane at base plus i
   generate
      for (genvar g = 0; g < `LRAM_LANES; g++) begin : g_lane
         logic [3:0] ka;
         logic [3:0] kb;
         assign ka = 4'(g) - unit_a[3:0];
         assign kb = 4'(g) - unit_b[3:0];
         assign lane_a[g] = cfg_q.nine ? wsrc_a[9*ka +: 9] : {1'b0, wsrc_a[8*ka +: 8]};
         assign lane_b[g] = cfg_q.nine ? rb_q.din[9*kb[2:0] +: 9] :
                            {1'b0, rb_q.din[8*kb[2:0] +: 8]};
      end
   endgenerate

   // Array write; port B lands last on a shared lane
   always_ff @(posedge clk) begin
      for (int i = 0; i < `LRAM_LANES; i++) begin
         if (wen_a && mask_a[i]) begin
            mem[unit_a[15:4]][i] <= lane_a[i];
         end
         if (wen_b && mask_b[i]) begin
            mem[unit_b[15:4]][i] <= lane_b[i];
         end
      end
   end

   // Read side: simple dual and FIFO read on port B with read_strobe
   always_comb begin
      raddr_b = (mode == lram_pkg::LRAM_FIFO) ? rptr_q : rb_q.addr;
      raddr_a = (mode == lram_pkg::LRAM_SDP) ? rb_q.addr : ra_q.addr;
      unique case (mode)
         lram_pkg::LRAM_TDP: begin
            rd_a = act_a_q && !ra_q.we;
            rd_b = act_b_q && !rb_q.we;
         end
         lram_pkg::LRAM_SDP: begin
            rd_b = act_b_q && rb_q.rs;
            rd_a = rd_b && wide;
         end
         lram_pkg::LRAM_SP: begin
            rd_a = act_a_q && !ra_q.we;
            rd_b = 1'b0;
         end
         lram_pkg::LRAM_FIFO: begin
            rd_a = 1'b0;
            rd_b = pop;
         end
      endcase
      // 144-bit reads: port A lanes 0-7, port B lanes 8-15; array writes re-evaluate
      arr_a = rd_pack(raddr_a, wide ? `LRAM_W144 : cfg_q.wa, cfg_q.nine, 4'h0);
      arr_b = rd_pack(raddr_b, cfg_q.wb, cfg_q.nine, wide ? 4'h8 : 4'h0);
   end

   lram_out #(.W(`LRAM_PORT_DW)) u_out_a (
      .clk(clk),
      .rst_n(rst_a_n),
      .load(rd_a),
      .adv(ce_a | (ce_b & wide)),
      .bypass(cfg_q.byp_a),
      .d(arr_a),
      .q(dout_a)
   );

   lram_out #(.W(`LRAM_PORT_DW)) u_out_b (
      .clk(clk),
      .rst_n(rst_b_n),
      .load(rd_b),
      .adv(ce_b),
      .bypass(cfg_q.byp_b),
      .d(arr_b),
      .q(dout_b)
   );
endmodule : lram_top

// ===== sim/lram_checker.sv
// Concurrent checks on the RAM block's top-level ports.
// Assumes one clock domain; bound to every lram_top instance below.
`timescale 1ns/10ps
module lram_checker (
   input wire logic clk,             // Block clock
   input wire logic resetn,          // Reset, active low
   input wire logic avs_read,        // Register read
   input wire logic avs_write,       // Register write
   input wire logic avs_waitrequest, // Register wait
   input wire logic clr_a,           // Port A clear
   input wire logic ce_a,            // Port A enable
   input wire logic [71:0] dout_a,   // Port A data
   input wire logic clr_b,           // Port B clear
   input wire logic ce_b,            // Port B enable
   input wire logic [71:0] dout_b,   // Port B data
   input wire logic fifo_full,       // FIFO full
   input wire logic fifo_empty       // FIFO empty
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   property p_wait_resp;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait_resp: assert property (p_wait_resp) else $error("register answer late");
   property p_wait_one;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("wait low too long");
   property p_wait_cause;
      !avs_waitrequest |-> $past(avs_read || avs_write);
   endproperty
   a_wait_cause: assert property (p_wait_cause) else $error("answer without request");
   property p_clr_a;
      clr_a |-> dout_a == 72'h0;
   endproperty
   a_clr_a: assert property (p_clr_a) else $error("port A clear ignored");
   property p_clr_b;
      clr_b |-> dout_b == 72'h0;
   endproperty
   a_clr_b: assert property (p_clr_b) else $error("port B clear ignored");
   property p_hold_a;
      $changed(dout_a) |-> $past(ce_a) || $past(ce_a, 2) || clr_a || $past(clr_a)
         || $past(avs_write);
   endproperty
   a_hold_a: assert property (p_hold_a) else $error("port A data moved idle");
   property p_hold_b;
      $changed(dout_b) |-> $past(ce_b) || $past(ce_b, 2) || clr_b || $past(clr_b)
         || $past(avs_write);
   endproperty
   a_hold_b: assert property (p_hold_b) else $error("port B data moved idle");
   property p_flags;
      !(fifo_full && fifo_empty);
   endproperty
   a_flags: assert property (p_flags) else $error("full and empty together");
   property p_empty_rel;
      $rose(resetn) |-> fifo_empty;
   endproperty
   a_empty_rel: assert property (p_empty_rel) else $error("not empty after reset");
   c_answer: cover property (!avs_waitrequest);
   c_clear: cover property (clr_b);
   c_read: cover property ($changed(dout_b));
endmodule : lram_checker

bind lram_top lram_checker lram_checker_inst (.clk(clk), .resetn(resetn),
   .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
   .clr_a(clr_a), .ce_a(ce_a), .dout_a(dout_a), .clr_b(clr_b), .ce_b(ce_b),
   .dout_b(dout_b), .fifo_full(fifo_full), .fifo_empty(fifo_empty));

// ===== sim/lram_fab.sv
// Fabric-side driver of one RAM port: enable, clear and request.
// Assumes the bench calls its tasks from one sequence.
`timescale 1ns/10ps
module lram_fab (
   input wire logic clk,              // Port clock
   output logic ce,                   // Clock enable
   output logic clr,                  // Clear, active high
   output lram_pkg::lram_req_type req // Request
);
   initial begin
      ce = 1'b0;
      clr = 1'b0;
      req = '0;
   end
   // Request is captured at the second edge
   task automatic op(input logic en, input logic we, input logic [7:0] be,
      input logic [15:0] addr, input logic [71:0] din);
      @(posedge clk);
      ce <= en;
      req <= {we, ~we, be, addr, din};
      @(posedge clk);
   endtask : op
   // Released lines stop showing the last request
   task automatic idle();
      ce <= 1'b0;
      req.we <= 1'b0;
      req.addr <= ~req.addr;
      req.din <= ~req.din;
   endtask : idle
   task automatic clear();
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
   endtask : clear
endmodule : lram_fab

// ===== sim/testbench.sv
// Self-checking bench for the RAM block: config register and port data.
// Assumes lram_fab drives the fabric side of both ports.
`timescale 1ns/10ps
module testbench;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic clr_a;
   logic ce_a;
   logic clr_b;
   logic ce_b;
   lram_pkg::lram_req_type req_a;
   lram_pkg::lram_req_type req_b;
   logic [71:0] dout_a;
   logic [71:0] dout_b;
   logic fifo_full;
   logic fifo_empty;
   logic [31:0] r;
   logic [71:0] d1 = 72'h9a123456789abcdef0;
   logic [71:0] d2 = 72'h5c0fedcba987654321;
   logic [71:0] d3 = 72'h330011223344556677;
   logic [71:0] m;
   int fails = 0;
   int n_compared = 0;
   // Config written, config expected, refusal expected
   logic [31:0] rows [9][3] = '{'{32'h76c, 32'h76c, 32'h0}, '{32'h490, 32'h76c, 32'h1},
      '{32'h76d, 32'h76d, 32'h0}, '{32'h771, 32'h76d, 32'h1}, '{32'h491, 32'h491, 32'h0},
      '{32'h412, 32'h491, 32'h1}, '{32'h76e, 32'h76e, 32'h0}, '{32'h74f, 32'h76e, 32'h1},
      '{32'h76f, 32'h76f, 32'h0}};

   always #10 clk = ~clk;

   lram_top lram_top_inst (.clk(clk), .resetn(resetn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .clr_a(clr_a),
      .ce_a(ce_a), .req_a(req_a), .dout_a(dout_a), .clr_b(clr_b), .ce_b(ce_b),
      .req_b(req_b), .dout_b(dout_b), .fifo_full(fifo_full), .fifo_empty(fifo_empty));
   lram_fab fab_a (.clk(clk), .ce(ce_a), .clr(clr_a), .req(req_a));
   lram_fab fab_b (.clk(clk), .ce(ce_b), .clr(clr_b), .req(req_b));

   task automatic final_report();
      if (fails == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : final_report

   task automatic chk(input logic [71:0] got, input logic [71:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      avs_read <= ~w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      r = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         fails++;
         final_report();
      end
   endtask : av

   // Bypassed read on port B, data seen one edge after capture
   task automatic rdb(input logic [15:0] addr);
      fab_b.op(1'b1, 1'b0, 8'h00, addr, 72'h0);
      fab_b.idle();
      @(posedge clk);
      #1;
   endtask : rdb

   initial begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      av(1'b0, 4'h0, 32'h0);
      chk({40'h0, r}, 72'h400);
      av(1'b1, 4'hc, 32'hffffffff);
      av(1'b0, 4'hc, 32'h0);
      chk({40'h0, r}, 72'h0);
      for (int i = 0; i < 9; i++) begin
         av(1'b1, 4'h0, rows[i][0]);
         av(1'b0, 4'h0, 32'h0);
         chk({40'h0, r}, {40'h0, rows[i][1]});
         av(1'b0, 4'h4, 32'h0);
         chk({71'h0, r[0]}, {71'h0, rows[i][2][0]});
         av(1'b1, 4'h4, 32'h1);
      end
      av(1'b1, 4'h0, 32'h76c);
      fab_a.op(1'b1, 1'b1, 8'hff, 16'h5, d1);
      fab_a.idle();
      rdb(16'h5);
      chk(dout_b, d1);
      fab_a.op(1'b1, 1'b1, 8'h5a, 16'h5, d2);
      fab_a.idle();
      m = d1;
      for (int k = 0; k < 8; k++) begin
         if (k == 1 || k == 3 || k == 4 || k == 6) begin
            m[9*k +: 9] = d2[9*k +: 9];
         end
      end
      rdb(16'h5);
      chk(dout_b, m);
      fab_a.op(1'b0, 1'b1, 8'hff, 16'h5, d3);
      fab_a.idle();
      rdb(16'h5);
      chk(dout_b, m);
      fab_a.op(1'b1, 1'b1, 8'hff, 16'h6, d3);
      fab_a.idle();
      av(1'b1, 4'h0, 32'h46c);
      fab_b.op(1'b1, 1'b0, 8'h00, 16'h5, 72'h0);
      repeat (2) @(posedge clk);
      fab_b.op(1'b1, 1'b0, 8'h00, 16'h6, 72'h0);
      @(posedge clk);
      #1;
      chk(dout_b, m);
      @(posedge clk);
      fab_b.idle();
      #1;
      chk(dout_b, d3);
      fab_b.clear();
      #1;
      chk(dout_b, 72'h0);
      fab_a.clear();
      fab_a.op(1'b1, 1'b0, 8'h00, 16'h6, 72'h0);
      repeat (2) @(posedge clk);
      fab_a.idle();
      #1;
      chk(dout_a, d3);
      av(1'b1, 4'h0, 32'h76c);
      fab_b.op(1'b1, 1'b1, 8'h0f, 16'h6, d1);
      fab_b.idle();
      rdb(16'h6);
      chk(dout_b, {d3[71:36], d1[35:0]});
      av(1'b1, 4'h0, 32'h36c);
      fab_a.op(1'b1, 1'b1, 8'hff, 16'h7, d2);
      fab_a.idle();
      rdb(16'h7);
      chk(dout_b, {8'h00, d2[63:0]});
      av(1'b1, 4'h0, 32'h76f);
      fab_a.op(1'b1, 1'b1, 8'hff, 16'h0, d1);
      fab_a.idle();
      fab_a.op(1'b1, 1'b1, 8'hff, 16'h0, d2);
      fab_a.idle();
      chk({70'h0, fifo_full, fifo_empty}, 72'h0);
      rdb(16'h0);
      chk(dout_b, d1);
      rdb(16'h0);
      chk(dout_b, d2);
      chk({70'h0, fifo_full, fifo_empty}, 72'h1);
      final_report();
   end
endmodule : testbench
